// ===== logic/pcmssi_params.svh
// Constants for the serial voice port timing block (modes 2 to 6).
// Assumes a 50 MHz aclk and a 32-bit AXI4-Lite register bus.
// Operation
// - Flex TDM slave: sync and clock in, clock and strobe outputs off
// - Flex TDM: rate from cycles field, not select
// - Cycles per frame accepted from 8 to 2047
// - SSI master drives both strobes and clock
// - Master rate code: 16 bits doubling per code
// - SSI slave: far end drives strobes, clock
// - SSI slave reports measured bits per frame
// - 8 bits: one short; 16: two short/one long
// - Flex SSI slave: cycles field, first strobe
// - Auto mode detects rate, strobes, channel sizes
// - Non-power rates report measured cycle count
// - Detected code 000=16 bits, doubling to 2048
// - Half-rate flex: even values 16 to 2046
// - Mode from four control bits, others idle
`ifndef PCMSSI_PARAMS_SVH
`define PCMSSI_PARAMS_SVH

`define PCMSSI_CLK_NS       20
`define PCMSSI_BASE_KHZ     128
`define PCMSSI_BASE_BITS    16

// Register byte offsets
`define PCMSSI_CTRL_OFS     8'h00
`define PCMSSI_CCPF_OFS     8'h04
`define PCMSSI_STAT_OFS     8'h08
`define PCMSSI_STRB_OFS     8'h0c
`define PCMSSI_TXD_OFS      8'h10
`define PCMSSI_RXD_OFS      8'h14

// Control fields
`define PCMSSI_C_MASTER     0
`define PCMSSI_C_SMODE      1
`define PCMSSI_C_SREG       2
`define PCMSSI_C_FLEX       3
`define PCMSSI_C_RATE_LO    4
`define PCMSSI_C_RATE_HI    6
`define PCMSSI_C_RESTART    7
`define PCMSSI_C_LOOPSEL    8
`define PCMSSI_C_HALF       9
`define PCMSSI_C_LONG       10
`define PCMSSI_C_TWO        11
`define PCMSSI_C_POS_LO     16
`define PCMSSI_C_POS_HI     26
`define PCMSSI_CTRL_RST     32'h0000_0000
`define PCMSSI_CCPF_RST     11'h100

// Cycles-per-frame limits
`define PCMSSI_CCPF_MIN     11'h008
`define PCMSSI_CCPF_HMIN    11'h010
`define PCMSSI_CCPF_HMAX    11'h7fe

// Status, strobe and receive data fields
`define PCMSSI_S_EXACT      3
`define PCMSSI_S_MODE_LO    4
`define PCMSSI_S_CFGERR     7
`define PCMSSI_S_LENERR     8
`define PCMSSI_S_OVR        9
`define PCMSSI_S_RXV        10
`define PCMSSI_S_MEAS_LO    16
`define PCMSSI_B_LONG1      16
`define PCMSSI_B_LONG2      17
`define PCMSSI_R_CH         16
`define PCMSSI_R_VALID      31

`define PCMSSI_SHORT_BITS   8
`define PCMSSI_LONG_BITS    16
`define PCMSSI_RESP_OKAY    2'b00
`define PCMSSI_RESP_SLVERR  2'b10

`endif

// ===== logic/pcmssi_pkg.sv
// Types shared by the serial voice port timing block.
// Assumes nothing beyond a SystemVerilog compiler.
`default_nettype none
package pcmssi_pkg;
  // Gray steps along the usual master, slave, flex, auto path
  typedef enum logic [2:0] {
    MD_IDLE     = 3'b000,
    MD_TDM_FLEX = 3'b001,
    MD_SSI_MST  = 3'b011,
    MD_SSI_SLV  = 3'b010,
    MD_SSI_FLEX = 3'b110,
    MD_SSI_AUTO = 3'b111
  } pcmssi_mode_t;
endpackage
`default_nettype wire

// ===== logic/pcmssi_fifo.sv
// Receive word FIFO with valid/ready on both sides.
// Assumes one clock shared with both sides.
`timescale 1ns/1ps
`default_nettype none
module pcmssi_fifo #(
  parameter int W     = 17,
  parameter int DEPTH = 16
)(
  // Clock and reset
  input  wire logic         aclk,
  input  wire logic         aresetn,
  // Filling side
  input  wire logic         in_valid,
  output logic              in_ready,
  input  wire logic [W-1:0] in_data,
  // Draining side
  output logic              out_valid,
  input  wire logic         out_ready,
  output logic [W-1:0]      out_data
);
  localparam int AW = $clog2(DEPTH);
  logic [W-1:0]  mem [DEPTH];
  logic [AW-1:0] wp_ff, rp_ff, nxt_wp, nxt_rp;
  logic [AW:0]   cnt_ff, nxt_cnt;
  logic          push, pop;

  always_comb begin
    in_ready  = (cnt_ff != (AW+1)'(DEPTH));
    out_valid = (cnt_ff != '0);
    out_data  = mem[rp_ff];
    push      = in_valid & in_ready;
    pop       = out_valid & out_ready;
    nxt_wp    = push ? AW'((32'(wp_ff) + 1) % DEPTH) : wp_ff;
    nxt_rp    = pop ? AW'((32'(rp_ff) + 1) % DEPTH) : rp_ff;
    nxt_cnt   = cnt_ff + (AW+1)'(push) - (AW+1)'(pop);
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      wp_ff  <= '0;
      rp_ff  <= '0;
      cnt_ff <= '0;
    end else begin
      wp_ff  <= nxt_wp;
      rp_ff  <= nxt_rp;
      cnt_ff <= nxt_cnt;
    end
  end

  // Storage needs no reset; occupancy guards every read
  always_ff @(posedge aclk) begin
    if (push) begin
      mem[wp_ff] <= in_data;
    end
  end
endmodule
`default_nettype wire

// ===== logic/pcmssi_port.sv
// Serial voice port timing for TDM flex slave and SSI modes 2 to 6.
// Assumes all pins arrive unsynchronised; registers over AXI4-Lite.
//
// The address map and the AXI4-Lite slave port were chosen for this implementation.
`timescale 1ns/1ps
`default_nettype none
`include "pcmssi_params.svh"
module pcmssi_port
  import pcmssi_pkg::*;
#(
  parameter int ADDR_W     = 8,
  parameter int CNT_W      = 12,
  parameter int FIFO_DEPTH = 16
)(
  // Clock and reset
  input  wire logic              aclk,
  input  wire logic              aresetn,
  // AXI4-Lite write
  input  wire logic [ADDR_W-1:0] s_axi_awaddr,
  input  wire logic              s_axi_awvalid,
  output logic                   s_axi_awready,
  input  wire logic [31:0]       s_axi_wdata,
  input  wire logic [3:0]        s_axi_wstrb,
  input  wire logic              s_axi_wvalid,
  output logic                   s_axi_wready,
  output logic [1:0]             s_axi_bresp,
  output logic                   s_axi_bvalid,
  input  wire logic              s_axi_bready,
  // AXI4-Lite read
  input  wire logic [ADDR_W-1:0] s_axi_araddr,
  input  wire logic              s_axi_arvalid,
  output logic                   s_axi_arready,
  output logic [31:0]            s_axi_rdata,
  output logic [1:0]             s_axi_rresp,
  output logic                   s_axi_rvalid,
  input  wire logic              s_axi_rready,
  // Link clocks and frame
  input  wire logic              bit_clock_in,
  input  wire logic              loop_clock_in,
  input  wire logic              frame_sync,
  output logic                   bit_clock_out_o,
  output logic                   bit_clock_out_oe,
  // Channel strobes
  input  wire logic              channel_strobe_first_i,
  output logic                   channel_strobe_first_o,
  output logic                   channel_strobe_first_oe,
  input  wire logic              channel_strobe_second_i,
  output logic                   channel_strobe_second_o,
  output logic                   channel_strobe_second_oe,
  // Serial data
  input  wire logic              serial_data_in,
  output logic                   serial_data_out_o,
  output logic                   serial_data_out_oe
);
  localparam int FW = 17;

  function automatic pcmssi_mode_t decode(input logic [31:0] c);
    logic [3:0] k;
    k = {c[`PCMSSI_C_MASTER], c[`PCMSSI_C_SMODE],
         c[`PCMSSI_C_SREG], c[`PCMSSI_C_FLEX]};
    case (k)
      4'b0001, 4'b0011: decode = MD_TDM_FLEX;
      4'b1110:          decode = MD_SSI_MST;
      4'b0110:          decode = MD_SSI_SLV;
      4'b0111:          decode = MD_SSI_FLEX;
      4'b0100:          decode = MD_SSI_AUTO;
      default:          decode = MD_IDLE;
    endcase
  endfunction

  // Bus lanes merge one byte at a time
  function automatic logic [31:0] wmerge(input logic [31:0] o,
      input logic [31:0] n, input logic [3:0] s);
    for (int i = 0; i < 4; i++) begin
      if (s[i]) o[8*i +: 8] = n[8*i +: 8];
    end
    wmerge = o;
  endfunction

  // Exact power-of-two frame lengths from 16 to 2048 give a rate code
  function automatic logic [3:0] rate_code(input logic [CNT_W-1:0] n);
    rate_code = 4'h0;
    for (int k = 0; k < 8; k++) begin
      if (32'(n) == (`PCMSSI_BASE_BITS << k)) rate_code = {1'b1, 3'(k)};
    end
  endfunction

  // Half bit-clock period in aclk cycles, floored, never below one
  function automatic logic [CNT_W-1:0] half_div(input logic [2:0] r);
    int p;
    p = (1000000 / (`PCMSSI_BASE_KHZ << r)) / (2 * `PCMSSI_CLK_NS);
    half_div = (p < 1) ? CNT_W'(0) : CNT_W'(p - 1);
  endfunction

  // Bus and configuration state
  logic [ADDR_W-1:0] awa_ff, nxt_awa;
  logic [31:0]       wd_ff, nxt_wd, ctrl_ff, nxt_ctrl, ctl_a_ff, nxt_ctl_a;
  logic [31:0]       txd_ff, nxt_txd, rdata_c;
  logic [3:0]        ws_ff, nxt_ws;
  logic [10:0]       ccpf_ff, nxt_ccpf, ccpf_a_ff, nxt_ccpf_a;
  logic              aw_h_ff, nxt_aw_h, w_h_ff, nxt_w_h, cfgerr_ff, nxt_cfgerr;
  logic              awr_ff, nxt_awr, wr_ff, nxt_wr, bv_ff, nxt_bv;
  logic              arr_ff, nxt_arr, rv_ff, nxt_rv;
  logic [1:0]        br_ff, nxt_br, rr_ff, nxt_rr;
  logic [31:0]       rd_ff, nxt_rd;
  pcmssi_mode_t      mode_ff, nxt_mode, mode_c;
  logic              clr_ovr, pop, cfg_bad;
  // Link state
  logic [5:0]        s1_ff, s2_ff, s3_ff;
  logic [CNT_W-1:0]  cnt_ff, nxt_cnt, meas_ff, nxt_meas, div_ff, nxt_div;
  logic [CNT_W-1:0]  p1f_ff, nxt_p1f, p2r_ff, nxt_p2r, p2f_ff, nxt_p2f;
  logic [CNT_W-1:0]  fb, idx, wid, pos;
  logic [15:0]       sh_ff, nxt_sh;
  logic [4:0]        n_ff, nxt_n;
  logic [1:0]        ach_ff, nxt_ach, cur;
  logic [FW-1:0]     pd_ff, nxt_pd, fo_data;
  logic              pv_ff, nxt_pv, ovr_ff, nxt_ovr, bclk_ff, nxt_bclk;
  logic              do_ff, nxt_do, doe_ff, nxt_doe, bce_ff, nxt_bce;
  logic              s1o_ff, nxt_s1o, s2o_ff, nxt_s2o, soe_ff, nxt_soe;
  logic              fi_ready, fo_valid, lclk, lclk_p, ctick, tick, fstart;
  logic              slave, w1, w2, elong, etwo, mst_rise;
  logic [15:0]       txw;
  logic [3:0]        rc;

  // Two flops on every pin before any logic looks at it
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s1_ff <= '0;
      s2_ff <= '0;
      s3_ff <= '0;
    end else begin
      s1_ff <= {serial_data_in, channel_strobe_second_i,
                channel_strobe_first_i, frame_sync, loop_clock_in,
                bit_clock_in};
      s2_ff <= s1_ff;
      s3_ff <= s2_ff;
    end
  end

  always_comb begin
    nxt_awa = awa_ff;  nxt_wd = wd_ff;  nxt_ws = ws_ff;
    nxt_ctrl = ctrl_ff;  nxt_ccpf = ccpf_ff;  nxt_txd = txd_ff;
    nxt_ctl_a = ctl_a_ff;  nxt_ccpf_a = ccpf_a_ff;  nxt_mode = mode_ff;
    nxt_cfgerr = cfgerr_ff;  nxt_bv = bv_ff;  nxt_br = br_ff;
    nxt_rv = rv_ff;  nxt_rr = rr_ff;  nxt_rd = rd_ff;  clr_ovr = 1'b0;
    pop = 1'b0;
    if (s_axi_awvalid && awr_ff) nxt_awa = s_axi_awaddr;
    if (s_axi_wvalid && wr_ff) begin
      nxt_wd = s_axi_wdata;
      nxt_ws = s_axi_wstrb;
    end
    nxt_aw_h = aw_h_ff | (s_axi_awvalid & awr_ff);
    nxt_w_h  = w_h_ff | (s_axi_wvalid & wr_ff);
    if (nxt_aw_h && nxt_w_h && !bv_ff) begin
      nxt_aw_h = 1'b0;
      nxt_w_h  = 1'b0;
      nxt_bv   = 1'b1;
      nxt_br   = `PCMSSI_RESP_OKAY;
      case (nxt_awa)
        `PCMSSI_CTRL_OFS: nxt_ctrl = wmerge(ctrl_ff, nxt_wd, nxt_ws);
        `PCMSSI_CCPF_OFS: nxt_ccpf = 11'(wmerge({21'h0, ccpf_ff},
                                                nxt_wd, nxt_ws));
        `PCMSSI_TXD_OFS:  nxt_txd = wmerge(txd_ff, nxt_wd, nxt_ws);
        `PCMSSI_STAT_OFS: clr_ovr = nxt_ws[1] & nxt_wd[`PCMSSI_S_OVR];
        `PCMSSI_STRB_OFS, `PCMSSI_RXD_OFS: ;
        default: nxt_br = `PCMSSI_RESP_SLVERR;
      endcase
    end else if (bv_ff && s_axi_bready) begin
      nxt_bv = 1'b0;
    end
    nxt_awr = ~nxt_aw_h & ~nxt_bv;
    nxt_wr  = ~nxt_w_h & ~nxt_bv;
    // New settings act only on a low-to-high restart
    mode_c  = decode(nxt_ctrl);
    cfg_bad = (mode_c == MD_TDM_FLEX || mode_c == MD_SSI_FLEX) &&
              (nxt_ctrl[`PCMSSI_C_HALF] ?
                 (nxt_ccpf < `PCMSSI_CCPF_HMIN ||
                  nxt_ccpf > `PCMSSI_CCPF_HMAX || nxt_ccpf[0]) :
                 (nxt_ccpf < `PCMSSI_CCPF_MIN));
    if (nxt_ctrl[`PCMSSI_C_RESTART] && !ctrl_ff[`PCMSSI_C_RESTART]) begin
      nxt_ctl_a  = nxt_ctrl;
      nxt_ccpf_a = nxt_ccpf;
      nxt_cfgerr = cfg_bad | (mode_c == MD_IDLE);
      nxt_mode   = cfg_bad ? MD_IDLE : mode_c;
    end
    rc = rate_code(meas_ff);
    case (s_axi_araddr)
      `PCMSSI_CTRL_OFS: rdata_c = ctrl_ff;
      `PCMSSI_CCPF_OFS: rdata_c = {21'h0, ccpf_ff};
      // Code only on exact lengths, count always
      `PCMSSI_STAT_OFS: rdata_c = {4'h0, meas_ff, 5'h0, fo_valid, ovr_ff,
                                   32'(meas_ff) != {21'h0, ccpf_a_ff},
                                   cfgerr_ff, mode_ff, rc};
      `PCMSSI_STRB_OFS: rdata_c = {14'h0,
                                   p2f_ff - p2r_ff > CNT_W'(8),
                                   p1f_ff > CNT_W'(8),
                                   4'h0, p2r_ff - p1f_ff};
      `PCMSSI_TXD_OFS:  rdata_c = txd_ff;
      `PCMSSI_RXD_OFS:  rdata_c = {fo_valid, 14'h0, fo_data};
      default:          rdata_c = 32'h0;
    endcase
    if (s_axi_arvalid && arr_ff) begin
      nxt_rv = 1'b1;
      nxt_rd = rdata_c;
      pop    = (s_axi_araddr == `PCMSSI_RXD_OFS);
      nxt_rr = (rdata_c == 32'h0 && s_axi_araddr > `PCMSSI_RXD_OFS) ?
               `PCMSSI_RESP_SLVERR : `PCMSSI_RESP_OKAY;
    end else if (rv_ff && s_axi_rready) begin
      nxt_rv = 1'b0;
    end
    nxt_arr = ~nxt_rv;
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      awa_ff <= '0;  wd_ff <= '0;  ws_ff <= '0;  aw_h_ff <= 1'b0;
      w_h_ff <= 1'b0;  awr_ff <= 1'b0;  wr_ff <= 1'b0;  bv_ff <= 1'b0;
      br_ff <= '0;  arr_ff <= 1'b0;  rv_ff <= 1'b0;  rr_ff <= '0;
      rd_ff <= '0;  ctrl_ff <= `PCMSSI_CTRL_RST;
      ccpf_ff <= `PCMSSI_CCPF_RST;  txd_ff <= '0;
      ctl_a_ff <= `PCMSSI_CTRL_RST;  ccpf_a_ff <= `PCMSSI_CCPF_RST;
      mode_ff <= MD_IDLE;  cfgerr_ff <= 1'b0;
    end else begin
      awa_ff <= nxt_awa;  wd_ff <= nxt_wd;  ws_ff <= nxt_ws;
      aw_h_ff <= nxt_aw_h;  w_h_ff <= nxt_w_h;  awr_ff <= nxt_awr;
      wr_ff <= nxt_wr;  bv_ff <= nxt_bv;  br_ff <= nxt_br;
      arr_ff <= nxt_arr;  rv_ff <= nxt_rv;  rr_ff <= nxt_rr;
      rd_ff <= nxt_rd;  ctrl_ff <= nxt_ctrl;  ccpf_ff <= nxt_ccpf;
      txd_ff <= nxt_txd;  ctl_a_ff <= nxt_ctl_a;  ccpf_a_ff <= nxt_ccpf_a;
      mode_ff <= nxt_mode;  cfgerr_ff <= nxt_cfgerr;
    end
  end

  assign s_axi_awready = awr_ff;
  assign s_axi_wready  = wr_ff;
  assign s_axi_bvalid  = bv_ff;
  assign s_axi_bresp   = br_ff;
  assign s_axi_arready = arr_ff;
  assign s_axi_rvalid  = rv_ff;
  assign s_axi_rresp   = rr_ff;
  assign s_axi_rdata   = rd_ff;

  always_comb begin
    slave  = (mode_ff == MD_SSI_SLV || mode_ff == MD_SSI_FLEX ||
              mode_ff == MD_SSI_AUTO);
    // Far end supplies clock and frame
    lclk   = ctl_a_ff[`PCMSSI_C_LOOPSEL] ? s2_ff[1] : s2_ff[0];
    lclk_p = ctl_a_ff[`PCMSSI_C_LOOPSEL] ? s3_ff[1] : s3_ff[0];
    // Flex TDM frames on frame_sync, SSI slaves on first strobe
    fstart = (mode_ff == MD_TDM_FLEX) ? (s2_ff[2] & ~s3_ff[2]) :
             (slave & s2_ff[3] & ~s3_ff[3]);
    nxt_div  = div_ff;
    nxt_bclk = bclk_ff;
    mst_rise = 1'b0;
    if (mode_ff == MD_SSI_MST) begin
      if (div_ff == '0) begin
        nxt_div  = half_div(ctl_a_ff[`PCMSSI_C_RATE_HI:`PCMSSI_C_RATE_LO]);
        nxt_bclk = ~bclk_ff;
        mst_rise = ~bclk_ff;
      end else begin
        nxt_div = div_ff - CNT_W'(1);
      end
    end else begin
      nxt_div  = '0;
      nxt_bclk = 1'b0;
    end
    ctick = (mode_ff == MD_SSI_MST) ? mst_rise :
            ((mode_ff != MD_IDLE) & lclk & ~lclk_p);
    // Frame length in clocks: rate code, cycles field or measured
    case (mode_ff)
      MD_SSI_MST: fb = CNT_W'(`PCMSSI_BASE_BITS <<
                       ctl_a_ff[`PCMSSI_C_RATE_HI:`PCMSSI_C_RATE_LO]);
      MD_TDM_FLEX, MD_SSI_FLEX: fb = CNT_W'(ccpf_a_ff);
      default:    fb = meas_ff;
    endcase
    // Half rate: one data bit per two clocks
    idx  = ctl_a_ff[`PCMSSI_C_HALF] ? (cnt_ff >> 1) : cnt_ff;
    tick = ctick & (~ctl_a_ff[`PCMSSI_C_HALF] | cnt_ff[0]);
    if (ctl_a_ff[`PCMSSI_C_HALF]) fb = fb >> 1;
    // Channel limits for short frames
    elong = ctl_a_ff[`PCMSSI_C_LONG] & (fb >= CNT_W'(`PCMSSI_LONG_BITS));
    wid   = elong ? CNT_W'(`PCMSSI_LONG_BITS) : CNT_W'(`PCMSSI_SHORT_BITS);
    etwo  = ctl_a_ff[`PCMSSI_C_TWO] & (fb >= (wid << 1));
    pos   = CNT_W'(ctl_a_ff[`PCMSSI_C_POS_HI:`PCMSSI_C_POS_LO]);
    if (slave) begin
      w1 = s2_ff[3];
      w2 = s2_ff[4] & (etwo | (mode_ff == MD_SSI_AUTO));
    end else begin
      w1 = (mode_ff != MD_IDLE) & (idx < wid);
      w2 = etwo & (idx >= pos) & (idx < pos + wid);
    end
    nxt_cnt  = cnt_ff;
    nxt_meas = meas_ff;
    if (mode_ff == MD_IDLE) begin
      nxt_cnt = '0;
    end else if (fstart) begin
      nxt_meas = cnt_ff;
      nxt_cnt  = '0;
    end else if (ctick) begin
      if (!slave && cnt_ff >= CNT_W'(fb << ctl_a_ff[`PCMSSI_C_HALF]) -
          CNT_W'(1)) begin
        nxt_cnt = '0;
      end else if (cnt_ff != '1) begin
        nxt_cnt = cnt_ff + CNT_W'(1);
      end
    end
    // Strobe edge positions for channel size and gap
    nxt_p1f = (s3_ff[3] & ~s2_ff[3]) ? idx : p1f_ff;
    nxt_p2r = (s2_ff[4] & ~s3_ff[4]) ? idx : p2r_ff;
    nxt_p2f = (s3_ff[4] & ~s2_ff[4]) ? idx : p2f_ff;
    cur     = w1 ? 2'd1 : (w2 ? 2'd2 : 2'd0);
    nxt_sh  = sh_ff;
    nxt_n   = n_ff;
    nxt_ach = ach_ff;
    nxt_pd  = pd_ff;
    nxt_pv  = pv_ff & ~fi_ready;
    nxt_do  = do_ff;
    nxt_doe = doe_ff;
    // Hardware set wins over software clear
    nxt_ovr = ovr_ff & ~clr_ovr;
    txw     = (cur == 2'd2) ? txd_ff[31:16] : txd_ff[15:0];
    if (tick) begin
      if (ach_ff != 2'd0 && cur != ach_ff) begin
        if (pv_ff && !fi_ready) begin
          nxt_ovr = 1'b1;
        end else begin
          nxt_pd = {ach_ff == 2'd2, sh_ff};
          nxt_pv = 1'b1;
        end
      end
      nxt_n = (cur != 2'd0 && cur == ach_ff) ? n_ff + 5'd1 : 5'd1;
      if (cur != 2'd0) nxt_sh = {sh_ff[14:0], s2_ff[5]};
      if (cur == 2'd0) nxt_n = 5'd0;
      nxt_doe = (cur != 2'd0);
      // Bit leaves on the edge it is due, MSB first
      nxt_do  = (cur != 2'd0) && (nxt_n <= 5'(wid)) &&
                txw[4'(wid - CNT_W'(nxt_n))];
      nxt_ach = cur;
    end
    nxt_bce = (mode_ff == MD_SSI_MST);
    nxt_soe = (mode_ff == MD_SSI_MST);
    nxt_s1o = nxt_soe & w1;
    nxt_s2o = nxt_soe & w2;
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      cnt_ff <= '0;  meas_ff <= '0;  div_ff <= '0;  bclk_ff <= 1'b0;
      p1f_ff <= '0;  p2r_ff <= '0;  p2f_ff <= '0;  sh_ff <= '0;
      n_ff <= '0;  ach_ff <= '0;  pd_ff <= '0;  pv_ff <= 1'b0;
      ovr_ff <= 1'b0;  do_ff <= 1'b0;  doe_ff <= 1'b0;  bce_ff <= 1'b0;
      soe_ff <= 1'b0;  s1o_ff <= 1'b0;  s2o_ff <= 1'b0;
    end else begin
      cnt_ff <= nxt_cnt;  meas_ff <= nxt_meas;  div_ff <= nxt_div;
      bclk_ff <= nxt_bclk;  p1f_ff <= nxt_p1f;  p2r_ff <= nxt_p2r;
      p2f_ff <= nxt_p2f;  sh_ff <= nxt_sh;  n_ff <= nxt_n;
      ach_ff <= nxt_ach;  pd_ff <= nxt_pd;  pv_ff <= nxt_pv;
      ovr_ff <= nxt_ovr;  do_ff <= nxt_do;  doe_ff <= nxt_doe;
      bce_ff <= nxt_bce;  soe_ff <= nxt_soe;  s1o_ff <= nxt_s1o;
      s2o_ff <= nxt_s2o;
    end
  end

  assign bit_clock_out_o          = bclk_ff;
  assign bit_clock_out_oe         = bce_ff;
  assign channel_strobe_first_o   = s1o_ff;
  assign channel_strobe_first_oe  = soe_ff;
  assign channel_strobe_second_o  = s2o_ff;
  assign channel_strobe_second_oe = soe_ff;
  assign serial_data_out_o        = do_ff;
  assign serial_data_out_oe       = doe_ff;

  pcmssi_fifo #(
    .W     (FW),
    .DEPTH (FIFO_DEPTH)
  ) u_rx_fifo (
    .aclk      (aclk),
    .aresetn   (aresetn),
    .in_valid  (pv_ff),
    .in_ready  (fi_ready),
    .in_data   (pd_ff),
    .out_valid (fo_valid),
    .out_ready (pop),
    .out_data  (fo_data)
  );
endmodule
`default_nettype wire

// ===== tb/pcmssi_properties.sv
// Port-level checks for the serial voice port timing block.
// Assumes a bind to pcmssi_port; sees only that module's ports.
`timescale 1ns/1ps
`default_nettype none
module pcmssi_properties (
  // Clock and reset
  input wire logic        aclk,
  input wire logic        aresetn,
  // Register bus
  input wire logic        s_axi_awvalid,
  input wire logic        s_axi_awready,
  input wire logic        s_axi_wvalid,
  input wire logic        s_axi_wready,
  input wire logic [1:0]  s_axi_bresp,
  input wire logic        s_axi_bvalid,
  input wire logic        s_axi_bready,
  input wire logic        s_axi_arvalid,
  input wire logic        s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic        s_axi_rvalid,
  input wire logic        s_axi_rready,
  // Link pins
  input wire logic        bit_clock_out_oe,
  input wire logic        channel_strobe_first_oe
);
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  a_write_answer: assert property (s_axi_awvalid && s_axi_awready &&
    s_axi_wvalid && s_axi_wready |=> s_axi_bvalid)
    else $error("write response late");
  a_bresp_holds: assert property (s_axi_bvalid && !s_axi_bready |=>
    s_axi_bvalid && $stable(s_axi_bresp)) else $error("bresp dropped");
  a_read_answer: assert property (s_axi_arvalid && s_axi_arready |=>
    s_axi_rvalid) else $error("read data late");
  a_rdata_holds: assert property (s_axi_rvalid && !s_axi_rready |=>
    s_axi_rvalid && $stable(s_axi_rdata)) else $error("rdata dropped");
  a_aw_blocked: assert property (s_axi_awvalid && s_axi_awready |=>
    !s_axi_awready) else $error("awready during write");
  a_ar_blocked: assert property (s_axi_arvalid && s_axi_arready |=>
    !s_axi_arready [*1]) else $error("arready during read");
  a_reset_quiet: assert property (disable iff (1'b0) !aresetn |=>
    !s_axi_bvalid && !s_axi_rvalid && !bit_clock_out_oe)
    else $error("outputs active in reset");
  a_master_pins: assert property (
    bit_clock_out_oe == channel_strobe_first_oe)
    else $error("clock and strobe drive differ");
endmodule
bind pcmssi_port pcmssi_properties u_props (
  .aclk, .aresetn, .s_axi_awvalid, .s_axi_awready, .s_axi_wvalid,
  .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
  .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rvalid,
  .s_axi_rready, .bit_clock_out_oe, .channel_strobe_first_oe
);
`default_nettype wire

// ===== tb/pcmssi_far_end.sv
// Far-end codec model: bit clock, both strobes and serial data.
// Assumes the port samples data on rising bit clock edges.
`timescale 1ns/1ps
`default_nettype none
module pcmssi_far_end (
  // Link pins toward the port
  output logic bit_clk,
  output logic strobe_one,
  output logic strobe_two,
  output logic data
);
  initial begin
    bit_clk = 1'b0;
    strobe_one = 1'b0;
    strobe_two = 1'b0;
    data = 1'b0;
  end
  // Clock stands still between frames; released data keeps toggling
  task automatic send(input logic [15:0] w, input int nb, input int hp);
    for (int i = 0; i < nb; i++) begin
      strobe_one = (i < 16);
      strobe_two = 1'b0;
      data = (i < 16) ? w[15-i] : ~data;
      #hp bit_clk = 1'b1;
      #hp bit_clk = 1'b0;
    end
  endtask
endmodule
`default_nettype wire

// ===== tb/pcmssi_port_bench.sv
// Self-checking bench for the serial voice port timing block.
// Assumes the far-end model and the bound property checker.
`timescale 1ns/1ps
`default_nettype none
module pcmssi_port_bench;
  import pcmssi_pkg::*;
  logic aclk = 1'b0, aresetn = 1'b0;
  logic [7:0] s_axi_awaddr, s_axi_araddr;
  logic [31:0] s_axi_wdata, s_axi_rdata, m;
  logic [1:0] s_axi_bresp, s_axi_rresp;
  logic s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid;
  logic s_axi_rready, s_axi_awready, s_axi_wready, s_axi_bvalid;
  logic s_axi_arready, s_axi_rvalid, bck, s1, s2, sd, clk_oe;
  logic [1:0] bq[$];
  logic [33:0] rq[$];
  logic [31:0] mq[$];
  logic [15:0] w[18];
  logic [11:0] ctl[12] = '{12'h008, 12'h007, 12'h006, 12'h00e, 12'h002,
    12'h003, 12'h008, 12'h008, 12'h008, 12'h208, 12'h208, 12'h208};
  logic [10:0] cpf[12] = '{11'h100, 11'h100, 11'h100, 11'h100, 11'h100,
    11'h100, 11'h007, 11'h008, 11'h7ff, 11'h7ff, 11'h00e, 11'h7fe};
  logic [7:0] st[12] = '{8'h10, 8'h30, 8'h20, 8'h60, 8'h70, 8'h80,
    8'h80, 8'h10, 8'h10, 8'h80, 8'h80, 8'h10};
  int n_errors = 0, checks_done = 0;
  int seed;
  always #10 aclk = ~aclk;
  pcmssi_port DUT (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid,
    .s_axi_awready, .s_axi_wdata, .s_axi_wstrb(4'hf), .s_axi_wvalid,
    .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
    .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
    .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .bit_clock_in(bck),
    .loop_clock_in(1'b0), .frame_sync(s1), .bit_clock_out_o(),
    .bit_clock_out_oe(clk_oe), .channel_strobe_first_i(s1),
    .channel_strobe_first_o(), .channel_strobe_first_oe(),
    .channel_strobe_second_i(s2), .channel_strobe_second_o(),
    .channel_strobe_second_oe(), .serial_data_in(sd),
    .serial_data_out_o(), .serial_data_out_oe());
  pcmssi_far_end far (.bit_clk(bck), .strobe_one(s1), .strobe_two(s2),
    .data(sd));
  task check(input string nm, input logic [33:0] seen, exp);
    checks_done++;
    if (seen !== exp) begin
      n_errors++;
      $display("unexpected %s: expected %h seen %h", nm, exp, seen);
    end
  endtask
  task close_out;
    $display("checks %0d mismatches %0d", checks_done, n_errors);
    if (n_errors == 0 && checks_done > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask
  // Ready starts low at random to exercise slave-side holding
  task wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] e);
    bq.push_back(e);
    @(posedge aclk);
    {s_axi_awaddr, s_axi_wdata, s_axi_awvalid, s_axi_wvalid} <= {a, d, 2'b11};
    s_axi_bready <= $random(seed) & 1;
    forever begin
      @(posedge aclk);
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
      if (s_axi_bvalid && s_axi_bready) break;
      s_axi_bready <= 1'b1;
    end
    s_axi_bready <= 1'b0;
  endtask
  task rd(input logic [7:0] a, input logic [33:0] e, input logic [31:0] k);
    rq.push_back(e);
    mq.push_back(k);
    @(posedge aclk);
    {s_axi_araddr, s_axi_arvalid} <= {a, 1'b1};
    s_axi_rready <= $random(seed) & 1;
    forever begin
      @(posedge aclk);
      if (s_axi_arready) s_axi_arvalid <= 1'b0;
      if (s_axi_rvalid && s_axi_rready) break;
      s_axi_rready <= 1'b1;
    end
    s_axi_rready <= 1'b0;
  endtask
  task cfg(input logic [31:0] c);
    wr(8'h00, c, 2'b00);
    wr(8'h00, c | 32'h80, 2'b00);
  endtask
  always @(posedge aclk) begin
    if (s_axi_bvalid && s_axi_bready)
      check("bresp", {32'h0, s_axi_bresp}, {32'h0, bq.pop_front()});
    if (s_axi_rvalid && s_axi_rready) begin
      m = mq.pop_front();
      check("read", {s_axi_rresp, s_axi_rdata & m}, rq.pop_front());
    end
  end
  initial begin
    #1_000_000;
    n_errors++;
    close_out();
  end
  initial begin
    seed = 32'hb6fd62e1;
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready} = 3'b000;
    {s_axi_arvalid, s_axi_rready, s_axi_awaddr, s_axi_araddr} = '0;
    s_axi_wdata = '0;
    repeat (12) @(posedge aclk);
    aresetn <= 1'b1;
    rd(8'h00, 34'h0, 32'hffff_ffff);
    rd(8'h04, 34'h100, 32'h7ff);
    rd(8'h18, {2'b10, 32'h0}, 32'hffff_ffff);
    wr(8'h1c, 32'h1, 2'b10);
    $display("test register map done");
    for (int k = 0; k < 12; k++) begin
      wr(8'h04, {21'h0, cpf[k]}, 2'b00);
      cfg({20'h0, ctl[k]});
      rd(8'h08, {26'h0, st[k]}, 32'hf0);
      check("clock_oe", 34'(clk_oe), 34'(st[k] == 8'h30));
    end
    $display("test mode select done");
    wr(8'h04, 32'h100, 2'b00);
    cfg(32'h446);
    for (int k = 0; k < 18; k++) begin
      w[k] = 16'($random(seed));
      far.send(w[k], 32, (k == 5) ? 120 : 80);
    end
    rd(8'h08, 34'h0020_0209, 32'h0fff_020f);
    for (int k = 0; k < 16; k++)
      rd(8'h14, {18'h0_8000, w[k]}, 32'h8001_ffff);
    $display("test slave traffic done");
    // Overrun flag clears on a written one
    wr(8'h08, 32'h200, 2'b00);
    rd(8'h08, 34'h0, 32'h200);
    // Flex TDM: frame_sync from the far end, rate field set but unused
    wr(8'h04, 32'h20, 2'b00);
    cfg(32'h478);
    far.send(w[17], 32, 80);
    rd(8'h14, {18'h0_8000, w[16]}, 32'h8001_ffff);
    rd(8'h14, {18'h0_8000, w[17]}, 32'h8001_ffff);
    check("clock_oe", 34'(clk_oe), 34'h0);
    $display("test flex tdm done");
    close_out();
  end
endmodule
`default_nettype wire
